// [inc/reporter_pkg.sv]
// constants and types for the serial reading reporter
// Notes on behaviour
// (RQ1) link runs at 9600 baud by default, same rate both directions
// (RQ2) each character is eight data bits, no parity, one stop bit
// (RQ3) any received character triggers a six-character reply of the shown reading
// (RQ4) always six characters, fifth digit is the least significant digit
// (RQ5) after the reply the transmitter idles until the next character arrives
// (RQ6) reply has no STX, ETX or carriage return; sending stops after last digit (code ends the reply on the point when it sits after the last digit)
// (RQ7) three wires only: receive, transmit, common; no handshake lines
// (RQ8) optional faster bit rate up to 56K baud, same framing and reply
// (RQ9) ASCII digits and period, most significant first, each character LSB first
package reporter_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BAUD_DEFAULT = 9600;
    localparam int unsigned BAUD_MAX = 56000;
    localparam int unsigned DIV_DEFAULT = CLK_HZ / BAUD_DEFAULT;
    localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
    localparam int DIV_W = 16;
    localparam int DATA_W = 8;
    localparam int DIGITS = 5;
    localparam int CHARS = 6;
    localparam int POS_W = 3;
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] FRAME_BITS = 4'h9;
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_POINT = 8'h2e;
    localparam logic [POS_W-1:0] POINT_NONE = 3'h7;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_STOP = 2'b11
    } rx_state_t;
    typedef enum logic [1:0] {
        RP_IDLE = 2'b00,
        RP_SEND = 2'b01,
        RP_WAIT = 2'b10
    } rp_state_t;
endpackage

// [inc/byte_stream_if.sv]
// valid/ready byte carrier between the reply sequencer and the transmitter
`timescale 1ns/100ps
interface byte_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// [verilog/skid_buffer.sv]
// two-entry valid/ready buffer
`timescale 1ns/100ps
module skid_buffer (
    input wire logic clk_i,
    input wire logic rst_n_i,
    byte_stream_if.snk in_s,
    byte_stream_if.src out_s
);
    import reporter_pkg::*;
    logic [DATA_W-1:0] mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_s.ready = (cnt_q != 2'h2);
    assign out_s.valid = (cnt_q != 2'h0);
    assign out_s.data = mem_q[rd_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_s.data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    never_over_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) cnt_q <= 2'h2)
        else $error("buffer count above two");
endmodule

// [verilog/uart_tx.sv]
// serial transmitter, 8N1, lsb first
`timescale 1ns/100ps
module uart_tx (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] div_i,
    byte_stream_if.snk in_s,
    output logic tx_o,
    output logic busy_o
);
    import reporter_pkg::*;
    logic [DIV_W-1:0] cnt_q;
    logic [BIT_W-1:0] bit_q;
    logic [DATA_W:0] sh_q;
    logic busy_q;
    logic tick;

    assign tick = busy_q && (cnt_q == DIV_W'(1));
    assign in_s.ready = !busy_q;
    assign busy_o = busy_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
            bit_q <= '0;
            sh_q <= '1;
            tx_o <= 1'b1;
        end else if (!busy_q) begin
            if (in_s.valid) begin
                // start bit, then data lsb first, then a single stop
                busy_q <= 1'b1; // RQ2
                cnt_q <= div_i;
                bit_q <= '0;
                sh_q <= {1'b1, in_s.data}; // RQ9
                tx_o <= 1'b0;
            end
        end else if (tick) begin
            cnt_q <= div_i;
            if (bit_q == FRAME_BITS) begin
                busy_q <= 1'b0;
                tx_o <= 1'b1;
            end else begin
                bit_q <= bit_q + BIT_W'(1);
                tx_o <= sh_q[0]; // RQ9
                sh_q <= {1'b1, sh_q[DATA_W:1]};
            end
        end else begin
            cnt_q <= cnt_q - DIV_W'(1);
        end
    end

    idle_high_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
        (!busy_q && !in_s.valid) |=> tx_o) else $error("line not high while idle");
    start_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
        (!busy_q && in_s.valid) |=> !tx_o && busy_q) else $error("no start bit");
endmodule

// [verilog/serial_reading_reporter.sv]
// query-response serial port returning the displayed reading
`timescale 1ns/100ps
module serial_reading_reporter #(
    parameter int unsigned CLK_FREQ_HZ = reporter_pkg::CLK_HZ
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rx_i,
    output logic tx_o,
    input wire logic [19:0] reading_i,
    input wire logic [2:0] point_pos_i,
    input wire logic fast_en_i,
    input wire logic [15:0] fast_div_i,
    output logic busy_o
);
    import reporter_pkg::*;

    // ------------------------------------------------------------
    // bit rate selection
    // ------------------------------------------------------------
    // divisors follow the clock figure; a scaled figure shortens frames in simulation
    localparam int unsigned RATE_DIV = CLK_FREQ_HZ / BAUD_DEFAULT;
    localparam int unsigned FLOOR_DIV = CLK_FREQ_HZ / BAUD_MAX;
    logic [DIV_W-1:0] div;
    // special-order divisor below the floor is ignored and the default rate used, so it can never exceed the top rate
    always_comb begin
        div = DIV_W'(RATE_DIV); // RQ1
        if (fast_en_i && fast_div_i >= DIV_W'(FLOOR_DIV)) begin
            div = fast_div_i; // RQ8
        end
    end

    fast_pick_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ8
        (fast_en_i && fast_div_i >= DIV_W'(FLOOR_DIV)) |-> div == fast_div_i)
        else $error("fast rate not taken");
    div_floor_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ8
        div >= DIV_W'(FLOOR_DIV)) else $error("rate above maximum");
    default_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ1
        !fast_en_i |-> div == DIV_W'(RATE_DIV)) else $error("wrong default rate");

    // ------------------------------------------------------------
    // receive line synchroniser
    // ------------------------------------------------------------
    logic rx_m_q;
    logic rx_s_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= rx_i; // RQ7
            rx_s_q <= rx_m_q;
        end
    end

    // ------------------------------------------------------------
    // receiver: only the arrival of a character matters, not its value
    // ------------------------------------------------------------
    rx_state_t rx_q;
    logic [DIV_W-1:0] rcnt_q;
    logic [BIT_W-1:0] rbit_q;
    logic got_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_q <= RX_IDLE;
            rcnt_q <= '0;
            rbit_q <= '0;
            got_q <= 1'b0;
        end else begin
            got_q <= 1'b0;
            case (rx_q)
                RX_IDLE: begin
                    if (!rx_s_q) begin
                        rx_q <= RX_START;
                        rcnt_q <= div >> 1;
                    end
                end
                RX_START: begin
                    if (rcnt_q != '0) begin
                        rcnt_q <= rcnt_q - DIV_W'(1);
                    end else if (rx_s_q) begin
                        // glitch, not a real start bit
                        rx_q <= RX_IDLE;
                    end else begin
                        rx_q <= RX_DATA;
                        rcnt_q <= div - DIV_W'(1);
                        rbit_q <= '0;
                    end
                end
                RX_DATA: begin
                    if (rcnt_q != '0) begin
                        rcnt_q <= rcnt_q - DIV_W'(1);
                    end else begin
                        rcnt_q <= div - DIV_W'(1);
                        rbit_q <= rbit_q + BIT_W'(1);
                        if (rbit_q == BIT_W'(DATA_W - 1)) begin
                            rx_q <= RX_STOP; // RQ2
                        end
                    end
                end
                RX_STOP: begin
                    if (rcnt_q != '0) begin
                        rcnt_q <= rcnt_q - DIV_W'(1);
                    end else begin
                        rx_q <= RX_IDLE;
                        // framing error still counts as a query
                        got_q <= 1'b1; // RQ3
                    end
                end
                default: rx_q <= RX_IDLE;
            endcase
        end
    end

    one_query_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
        got_q |=> !got_q) else $error("one character seen twice");
    stop_seen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
        (rx_q == RX_STOP && rcnt_q == '0) |=> got_q) else $error("character not reported");
    data_bits_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ2
        (rx_q == RX_DATA) |-> rbit_q < BIT_W'(DATA_W)) else $error("too many data bits");

    // ------------------------------------------------------------
    // reply sequencer
    // ------------------------------------------------------------
    byte_stream_if seq_s ();
    byte_stream_if tx_s ();
    rp_state_t rp_q;
    logic [POS_W-1:0] pos_q;
    logic [POS_W-1:0] dig_q;
    logic [19:0] snap_q;
    logic [POS_W-1:0] pt_q;
    logic [7:0] chr_q;
    logic pend_q;

    function automatic logic [7:0] char_at(input logic [19:0] rd,
                                           input logic [POS_W-1:0] pt,
                                           input logic [POS_W-1:0] pos,
                                           input logic [POS_W-1:0] dig);
        logic [3:0] nib;
        nib = rd[19:16];
        case (dig)
            3'h0: nib = rd[19:16];
            3'h1: nib = rd[15:12];
            3'h2: nib = rd[11:8];
            3'h3: nib = rd[7:4];
            default: nib = rd[3:0];
        endcase
        if (pos == pt) begin
            char_at = ASCII_POINT; // RQ9
        end else begin
            char_at = ASCII_ZERO | {4'h0, nib}; // RQ9
        end
    endfunction

    assign seq_s.valid = (rp_q == RP_SEND);
    assign seq_s.data = chr_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rp_q <= RP_IDLE;
            pos_q <= '0;
            dig_q <= '0;
            snap_q <= '0;
            pt_q <= POINT_NONE;
            chr_q <= ASCII_ZERO;
            pend_q <= 1'b0;
        end else begin
            // a query that lands mid-reply is kept; further ones in the same reply merge into it
            if (got_q && rp_q != RP_IDLE) begin
                pend_q <= 1'b1; // RQ5
            end
            case (rp_q)
                RP_IDLE: begin
                    if (got_q || pend_q) begin
                        // a query landing as the pending one is taken waits its turn
                        pend_q <= got_q && pend_q; // RQ5
                        // freeze the reading so all six characters agree
                        snap_q <= reading_i; // RQ3
                        // point outside the group defaults to after the last digit
                        pt_q <= (point_pos_i < POS_W'(CHARS)) ? point_pos_i
                                                              : POS_W'(DIGITS); // RQ4
                        pos_q <= '0;
                        dig_q <= '0;
                        chr_q <= char_at(reading_i,
                                         (point_pos_i < POS_W'(CHARS)) ? point_pos_i
                                                                       : POS_W'(DIGITS),
                                         '0, '0);
                        rp_q <= RP_SEND;
                    end
                end
                RP_SEND: begin
                    if (seq_s.ready) begin
                        if (pos_q == POS_W'(CHARS - 1)) begin
                            // nothing appended after the last character
                            rp_q <= RP_WAIT; // RQ6
                        end else begin
                            pos_q <= pos_q + POS_W'(1);
                            if (pos_q != pt_q) begin
                                dig_q <= dig_q + POS_W'(1);
                                chr_q <= char_at(snap_q, pt_q, pos_q + POS_W'(1),
                                                 dig_q + POS_W'(1)); // RQ4
                            end else begin
                                chr_q <= char_at(snap_q, pt_q, pos_q + POS_W'(1), dig_q);
                            end
                        end
                    end
                end
                RP_WAIT: begin
                    if (!tx_s.valid && !busy_o) begin
                        rp_q <= RP_IDLE; // RQ5
                    end
                end
                default: rp_q <= RP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // buffer and transmitter
    // ------------------------------------------------------------
    skid_buffer u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_s(seq_s),
        .out_s(tx_s)
    );

    uart_tx u_tx (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .div_i(div),
        .in_s(tx_s),
        .tx_o(tx_o),
        .busy_o(busy_o)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [3:0] sent_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (rp_q == RP_IDLE && (got_q || pend_q))) begin
            sent_q <= '0;
        end else if (seq_s.valid && seq_s.ready) begin
            sent_q <= sent_q + 4'h1;
        end
    end

    // frames the transmitter took for the current reply
    logic [3:0] frames_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (rp_q == RP_IDLE && (got_q || pend_q))) begin
            frames_q <= '0;
        end else if (tx_s.valid && tx_s.ready) begin
            frames_q <= frames_q + 4'h1;
        end
    end

    // decimal points handed on in the current reply
    logic [2:0] dots_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || (rp_q == RP_IDLE && (got_q || pend_q))) begin
            dots_q <= '0;
        end else if (seq_s.valid && seq_s.ready && seq_s.data == ASCII_POINT) begin
            dots_q <= dots_q + 3'h1;
        end
    end

    six_chars_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ4
        (rp_q == RP_SEND) |-> sent_q < 4'h6) else $error("more than six chars");
    no_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ6
        seq_s.valid |-> seq_s.data != 8'h02 && seq_s.data != 8'h03 && seq_s.data != 8'h0d)
        else $error("control char in reply");
    ascii_only_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
        seq_s.valid |-> (seq_s.data == ASCII_POINT || seq_s.data[7:4] == 4'h3))
        else $error("non-ascii reply char");
    query_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
        (got_q && rp_q == RP_IDLE) |=> rp_q == RP_SEND) else $error("query ignored");
    idle_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
        (rp_q == RP_IDLE && !got_q && !pend_q) |=> !seq_s.valid)
        else $error("send without query");
    end_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
        (rp_q == RP_SEND && seq_s.ready && pos_q == POS_W'(CHARS - 1)) |=> rp_q == RP_WAIT)
        else $error("reply did not stop");
    reading_frozen_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
        (rp_q != RP_IDLE) |=> $stable(snap_q)) else $error("reading changed in reply");
    query_kept_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
        (got_q && rp_q != RP_IDLE) |=> pend_q) else $error("query lost mid-reply");
    pend_served_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ5
        (rp_q == RP_IDLE && pend_q) |=> rp_q == RP_SEND)
        else $error("pending query not answered");
    hold_char_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ9
        (seq_s.valid && !seq_s.ready) |=> seq_s.valid && $stable(seq_s.data))
        else $error("char dropped under stall");
    full_group_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ4
        (rp_q == RP_WAIT && !tx_s.valid && !busy_o) |-> frames_q == 4'(CHARS))
        else $error("reply not six frames");
    one_point_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ3
        (rp_q == RP_WAIT) |-> dots_q == 3'h1)
        else $error("reply without exactly one point");

    reply_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rp_q == RP_WAIT && sent_q == 4'h6);
    pend_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) pend_q);
    stall_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        seq_s.valid && !seq_s.ready);
    tail_point_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        rp_q == RP_SEND && pt_q == POS_W'(DIGITS));
    fast_rate_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        fast_en_i && div == fast_div_i);
endmodule

// [verification/host_model.sv]
// host side of the three-wire link: sends queries, collects reply characters
`timescale 1ns/100ps
module host_model (
    input wire logic clk_i,
    input wire logic from_dev_i,
    output logic to_dev_o
);
    // only data and common wires, no handshake lines
    initial begin
        to_dev_o = 1'b1;
    end

    // ----------------------------------------
    // query character: start, 8 data lsb first, stop
    // ----------------------------------------
    task automatic send_char(input logic [7:0] ch, input int div);
        for (int b = 0; b < 10; b++) begin
            @(posedge clk_i);
            to_dev_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : ch[b-1];
            // line rests high after the stop; return early to hear the reply start
            if (b < 9) begin
                repeat (div - 1) @(posedge clk_i);
            end
        end
    endtask

    // ----------------------------------------
    // reply character, sampled at mid-bit
    // ----------------------------------------
    task automatic recv_char(output logic [7:0] ch, output logic ok, input int div,
                             input int limit);
        int n;
        ok = 1'b0;
        ch = 8'h00;
        n = 0;
        while (from_dev_i !== 1'b0 && n < limit) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= limit) return;
        repeat (div / 2) @(posedge clk_i);
        if (from_dev_i !== 1'b0) return;
        for (int b = 0; b < 8; b++) begin
            repeat (div) @(posedge clk_i);
            ch[b] = from_dev_i;
        end
        repeat (div) @(posedge clk_i);
        ok = (from_dev_i === 1'b1);
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the serial reading reporter
`timescale 1ns/100ps
module testbench;
    import reporter_pkg::*;
    // the design is told of a 1 MHz clock, so a bit lasts 17 or 104 cycles
    localparam int unsigned SIM_HZ = 1_000_000;
    localparam int FAST = int'(SIM_HZ / BAUD_MAX);
    localparam int SLOW = int'(SIM_HZ / BAUD_DEFAULT);
    logic clk_i;
    logic rst_n_i;
    logic rx_i;
    logic tx_o;
    logic busy_o;
    logic fast_en_i;
    logic [15:0] fast_div_i;
    logic [19:0] reading_i;
    logic [2:0] point_pos_i;
    int n_fail = 0;
    int checks = 0;

    serial_reading_reporter #(.CLK_FREQ_HZ(SIM_HZ)) dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .rx_i(rx_i),
        .tx_o(tx_o),
        .reading_i(reading_i),
        .point_pos_i(point_pos_i),
        .fast_en_i(fast_en_i),
        .fast_div_i(fast_div_i),
        .busy_o(busy_o)
    );

    host_model host (
        .clk_i(clk_i),
        .from_dev_i(tx_o),
        .to_dev_o(rx_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] expect_char(input logic [19:0] rd, input logic [2:0] pt,
                                               input int i);
        int p;
        int k;
        p = (pt >= 3'h6) ? 5 : int'(pt);
        if (i == p) return 8'h2e;
        k = (i < p) ? i : i - 1;
        return 8'h30 + {4'h0, rd[19-4*k -: 4]};
    endfunction

    task automatic get_reply(input logic [19:0] rd, input logic [2:0] pt, input int div);
        logic [7:0] ch;
        logic ok;
        for (int i = 0; i < 6; i++) begin
            host.recv_char(ch, ok, div, 30 * div);
            check({7'h00, ok}, 8'h01, "reply frame");
            check(ch, expect_char(rd, pt, i), "reply char");
        end
    endtask

    // nothing more may start for two frame times
    task automatic expect_silence(input int div);
        logic low;
        low = 1'b0;
        repeat (20 * div) begin
            @(posedge clk_i);
            if (tx_o !== 1'b1) low = 1'b1;
        end
        check({7'h00, low}, 8'h00, "extra traffic");
        check({7'h00, busy_o}, 8'h00, "busy after reply");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_basic();
        reading_i <= 20'h12345;
        point_pos_i <= 3'h2;
        host.send_char(8'h3f, FAST);
        get_reply(20'h12345, 3'h2, FAST);
        expect_silence(FAST);
    endtask

    // control-code query, point beyond the end, zero digits
    task automatic s_tail_point();
        reading_i <= 20'h09870;
        point_pos_i <= 3'h7;
        host.send_char(8'h0d, FAST);
        get_reply(20'h09870, 3'h7, FAST);
        expect_silence(FAST);
    endtask

    // second query mid-reply, reading changes under the first reply
    task automatic s_overlap();
        reading_i <= 20'h55555;
        point_pos_i <= 3'h0;
        host.send_char(8'h51, FAST);
        fork
            get_reply(20'h55555, 3'h0, FAST);
            begin
                repeat (20 * FAST) @(posedge clk_i);
                reading_i <= 20'h24680;
                host.send_char(8'h00, FAST);
            end
        join
        get_reply(20'h24680, 3'h0, FAST);
        expect_silence(FAST);
    endtask

    task automatic s_default_rate();
        fast_en_i <= 1'b0;
        reading_i <= 20'h00123;
        point_pos_i <= 3'h4;
        host.send_char(8'hff, SLOW);
        get_reply(20'h00123, 3'h4, SLOW);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // about 13k cycles expected, mostly the default-rate reply
    initial begin
        repeat (40_000) @(posedge clk_i);
        n_fail++;
        $display("MISMATCH at %0t: run did not complete", $time);
        tally_and_finish();
    end

    initial begin
        rst_n_i = 1'b0;
        fast_en_i = 1'b1;
        fast_div_i = 16'(FAST);
        reading_i = 20'h00000;
        point_pos_i = 3'h0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check({7'h00, tx_o}, 8'h01, "idle line");
        check({7'h00, busy_o}, 8'h00, "idle busy");
        s_basic();
        s_tail_point();
        s_overlap();
        s_default_rate();
        tally_and_finish();
    end
endmodule
